/* File: rtl/crc_pkg.sv */
// package: constants and types for console run control
package crc_pkg;
    localparam int CLK_PERIOD_PS    = 4000;
    localparam int PULSE_SPACING_PS = 180000;
    localparam int PULSE_SPACING_CYC = PULSE_SPACING_PS / CLK_PERIOD_PS;
    localparam int TAP3_DELAY_PS    = 500000;
    localparam int TAP3_CYC         = TAP3_DELAY_PS / CLK_PERIOD_PS;
    localparam int SYNC_PERIOD_PS   = 363636;
    localparam int SYNC_PERIOD_CYC  = SYNC_PERIOD_PS / CLK_PERIOD_PS;
    localparam int SYNC_ODD_CYC     = SYNC_PERIOD_CYC / 2;
    localparam longint POWERUP_MS   = 5;
    localparam longint POWERUP_CYC  = (POWERUP_MS * 64'd1000000000) / CLK_PERIOD_PS;
    localparam int CHAIN_STAGES     = 8;
    localparam int CHAIN_EXCURSIONS = 3;
    localparam int WORD_W           = 8;
    localparam int ADDR_W           = 12;
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_ACCUM  = 8'h04;
    localparam logic [7:0] REG_PADDR  = 8'h08;
    localparam logic [7:0] REG_SDATA  = 8'h0C;
    localparam int ST_CENTER = 0;
    localparam int ST_CONT   = 1;
    localparam int ST_SINGLE = 2;
    localparam int ST_BUSY   = 3;
    localparam int ST_FAULT  = 4;
    localparam int ST_LOAD   = 5;
    localparam int ST_SWEPT  = 6;
    localparam int ST_EXC    = 8;
    localparam logic [WORD_W-1:0] ACCUM_RST = 8'h00;
    localparam logic [ADDR_W-1:0] PADDR_RST = 12'h000;
    localparam logic [WORD_W-1:0] SDATA_RST = 8'h00;

    typedef struct packed {
        logic run;
        logic step;
        logic load;
        logic clear;
        logic enter;
        logic sweep;
    } crc_lever_t;

    typedef enum logic [1:0] {
        CRC_CH_IDLE = 2'b00,
        CRC_CH_RUN  = 2'b01
    } crc_chain_st_t;
endpackage

/* File: rtl/crc_timing_chain.sv */
// eight-stage timing chain with excursion counter and recirculation
`timescale 1ns/1ps
module crc_timing_chain import crc_pkg::*; (
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    input  wire logic       i_start,
    input  wire logic       i_recirc,
    input  wire logic       i_halt,
    output logic            o_pulse,
    output logic [2:0]      o_stage,
    output logic [1:0]      o_exc,
    output logic            o_tap3,
    output logic            o_done,
    output logic            o_busy
);
    crc_chain_st_t st_r;
    logic [5:0]    sp_r;
    logic [6:0]    tap_r;
    logic          tap_act_r;
    logic          hold_r;
    logic [2:0]    stage_r;
    logic [1:0]    exc_r;
    logic          pulse_r;
    logic          done_r;
    logic          tap_r1;
    wire           tick      = (st_r == CRC_CH_RUN) && (sp_r == 6'(PULSE_SPACING_CYC - 1));
    wire           last_st   = (stage_r == 3'(CHAIN_STAGES - 1));
    wire           last_exc  = (exc_r == 2'(CHAIN_EXCURSIONS - 1));
    wire           tap_hit   = tap_act_r && (tap_r == 7'(TAP3_CYC - 1));

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_r    <= CRC_CH_IDLE;
            sp_r    <= 6'h00;
            stage_r <= 3'h0;
            exc_r   <= 2'h0;
            hold_r  <= 1'b0;
            pulse_r <= 1'b0;
            done_r  <= 1'b0;
        end else begin
            pulse_r <= tick;
            done_r  <= 1'b0;
            case (st_r)
                CRC_CH_IDLE: begin
                    if (i_start && !i_halt) begin
                        st_r    <= CRC_CH_RUN;
                        sp_r    <= 6'h00;
                        stage_r <= 3'h0;
                        exc_r   <= 2'h0;
                    end
                end
                CRC_CH_RUN: begin
                    sp_r <= tick ? 6'h00 : sp_r + 6'h01;
                    if (i_halt) begin
                        st_r <= CRC_CH_IDLE;
                    end else if (tick) begin
                        stage_r <= stage_r + 3'h1;
                        if (last_st && exc_r == 2'h1) begin
                            hold_r <= i_recirc;
                        end
                        if (last_st) begin
                            exc_r <= last_exc ? 2'h0 : exc_r + 2'h1;
                        end
                        if (last_st && last_exc) begin
                            done_r <= 1'b1;
                            if (!hold_r) begin
                                st_r <= CRC_CH_IDLE;
                            end
                        end
                    end
                end
                default: st_r <= CRC_CH_IDLE;
            endcase
        end
    end

    // one tap pulse per start, fixed delay after the start
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tap_r     <= 7'h00;
            tap_act_r <= 1'b0;
            tap_r1    <= 1'b0;
        end else begin
            tap_r1 <= tap_hit;
            if (i_start && st_r == CRC_CH_IDLE && !i_halt) begin
                tap_act_r <= 1'b1;
                tap_r     <= 7'h00;
            end else if (tap_hit) begin
                tap_act_r <= 1'b0;
            end else if (tap_act_r) begin
                tap_r <= tap_r + 7'h01;
            end
        end
    end

    assign o_pulse = pulse_r;
    assign o_stage = stage_r - 3'h1;
    assign o_exc   = exc_r;
    assign o_tap3  = tap_r1;
    assign o_done  = done_r;
    assign o_busy  = (st_r == CRC_CH_RUN);
endmodule // crc_timing_chain

/* File: rtl/crc_console_run_control.sv */
// top: console lever control, master clear, power fault, storage entry
//
// Operation
// - run lever up keeps storage reference cycles going continuously.
// - each step lever press gives exactly one storage cycle then halt.
// - lever in centre sets the centre flag.
// - run with centre flag set sets continuous latch on next even sync.
// - chain start issued on following odd sync unless load mode.
// - third chain tap clears centre flag, blocking a second start.
// - recirculation hold asserted as long as continuous latch set.
// - back to centre: flag set, latch cleared at odd sync, cycle finishes.
// - step sets single latch; tap clears both; chain stops after three passes.
// - load position drives load terms high, not-load low; tape read on lever.
// - clear gives master clear only when idle; zeroes three registers.
// - master clear goes out as internal and external signals.
// - enter mode writes accumulator to storage, clears it, bumps address.
// - sweep reads successive words, one advance per lever operation.
// - power failure stops machine, sets fault latch, blocks storage.
// - powerup delay input held low 5 ms forcing fault latch set.
// - each storage cycle is 24 pulses, three passes of eight stages; run recirculates without a new start.
// - chain pulses spaced 0.18 usec apart.
`timescale 1ns/1ps
module crc_console_run_control import crc_pkg::*; #(
    parameter int POWERUP_CYCLES = int'(POWERUP_CYC)
) (
    input  wire logic              I_REF_CLK,
    input  wire logic              I_RST_B,
    input  wire crc_lever_t        I_LEVERS,
    input  wire logic              I_POWER_OK,
    input  wire logic              I_POWERUP_DELAY_B,
    input  wire logic [7:0]        I_REG_ADDR,
    input  wire logic [31:0]       I_REG_WDATA,
    input  wire logic              I_REG_WR,
    input  wire logic              I_REG_RD,
    output logic [31:0]            O_REG_RDATA,
    input  wire logic [WORD_W-1:0] I_STORE_RDATA,
    output logic [ADDR_W-1:0]      O_STORE_ADDR,
    output logic [WORD_W-1:0]      O_STORE_WDATA,
    output logic                   O_STORE_WR,
    output logic                   O_STORE_RD,
    output logic                   O_CHAIN_START,
    output logic                   O_TIMING_PULSE,
    output logic [2:0]             O_CHAIN_STAGE,
    output logic [1:0]             O_EXCURSION,
    output logic                   O_CHAIN_THIRD_TAP,
    output logic                   O_RECIRC_HOLD,
    output logic                   O_LOAD_TERM,
    output logic                   O_NOT_LOAD_TERM,
    output logic                   O_TAPE_READ_START,
    output logic                   O_MASTER_CLEAR_INT,
    output logic                   O_MASTER_CLEAR_EXT,
    output logic                   O_POWER_FAULT,
    output logic                   O_STORAGE_ENABLE
);
    function automatic logic is_centre(input crc_lever_t l);
        return !l.run && !l.step;
    endfunction

    crc_lever_t        lev_s1_r;
    crc_lever_t        lev_s2_r;
    crc_lever_t        lev_r;
    logic [1:0]        pwr_s_r;
    logic [1:0]        dly_s_r;
    logic [6:0]        sync_r;
    logic [20:0]       pup_r;
    logic              pup_done_r;
    logic              center_r;
    logic              cont_r;
    logic              single_r;
    logic              fault_r;
    logic              clear_prev_r;
    logic              swept_r;
    logic              rd_pend_r;
    logic [WORD_W-1:0] acc_r;
    logic [ADDR_W-1:0] pa_r;
    logic [WORD_W-1:0] sd_r;
    logic              start_r;
    logic              tape_r;
    logic              mc_int_r;
    logic              mc_ext_r;
    logic              st_wr_r;
    logic              st_rd_r;
    logic [ADDR_W-1:0] st_addr_r;
    logic [WORD_W-1:0] st_wdata_r;
    logic [31:0]       rdata_r;
    logic              ch_pulse;
    logic              ch_tap;
    logic              ch_done;
    logic              ch_busy;
    logic [2:0]        ch_stage;
    logic [1:0]        ch_exc;

    wire even_sync  = (sync_r == 7'h00);
    wire odd_sync   = (sync_r == 7'(SYNC_ODD_CYC));
    wire lev_centre = is_centre(lev_r);
    wire running    = cont_r || ch_busy;
    wire delay_low  = !dly_s_r[1] || !pup_done_r;
    wire fault_set  = !pwr_s_r[1] || delay_low;
    wire start_ok   = odd_sync && center_r && (cont_r || single_r)
                      && !ch_busy && !fault_r;
    wire start_now  = start_ok && !lev_r.load;
    wire tape_now   = start_ok && lev_r.load;
    wire mc_now     = lev_r.clear && !clear_prev_r && !running;
    wire op_ok      = ch_done && !fault_r;
    wire enter_now  = op_ok && lev_r.enter;
    wire sweep_now  = op_ok && lev_r.sweep && !lev_r.enter && !swept_r;
    wire sel_status = (I_REG_ADDR == REG_STATUS);
    wire sel_accum  = (I_REG_ADDR == REG_ACCUM);
    wire sel_paddr  = (I_REG_ADDR == REG_PADDR);
    wire sel_sdata  = (I_REG_ADDR == REG_SDATA);
    wire [31:0] status_w = {22'h000000, ch_exc, 1'b0, swept_r, lev_r.load,
                            fault_r, ch_busy, single_r, cont_r, center_r};
    wire [31:0] rd_mux = sel_status ? status_w
                       : sel_accum  ? {24'h000000, acc_r}
                       : sel_paddr  ? {20'h00000, pa_r}
                       : sel_sdata  ? {24'h000000, sd_r}
                       : 32'h00000000;

    // sync pulse generator, even and odd half a period apart
    always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            sync_r <= 7'h00;
        end else begin
            sync_r <= (sync_r == 7'(SYNC_PERIOD_CYC - 1)) ? 7'h00 : sync_r + 7'h01;
        end
    end

    // two-flop synchronisers, then levers sampled on even sync
    always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            lev_s1_r <= '0;
            lev_s2_r <= '0;
            lev_r    <= '0;
            pwr_s_r  <= 2'h0;
            dly_s_r  <= 2'h0;
        end else begin
            lev_s1_r <= I_LEVERS;
            lev_s2_r <= lev_s1_r;
            pwr_s_r  <= {pwr_s_r[0], I_POWER_OK};
            dly_s_r  <= {dly_s_r[0], I_POWERUP_DELAY_B};
            if (even_sync) begin
                lev_r <= lev_s2_r;
            end
        end
    end

    // powerup hold keeps the delay input low after reset
    always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            pup_r      <= 21'h000000;
            pup_done_r <= 1'b0;
        end else if (!pup_done_r) begin
            pup_r      <= pup_r + 21'h000001;
            pup_done_r <= (pup_r == 21'(POWERUP_CYCLES - 1));
        end
    end

    // lever latches
    always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            center_r     <= 1'b1;
            cont_r       <= 1'b0;
            single_r     <= 1'b0;
            clear_prev_r <= 1'b0;
        end else begin
            clear_prev_r <= lev_r.clear;
            if (lev_centre) begin
                center_r <= 1'b1;
            end else if (ch_tap || tape_now) begin
                center_r <= 1'b0;
            end
            if (fault_r) begin
                cont_r <= 1'b0;
            end else if (even_sync && lev_r.run && center_r) begin
                cont_r <= 1'b1;
            end else if (odd_sync && center_r && !lev_r.run) begin
                cont_r <= 1'b0;
            end
            if (fault_r) begin
                single_r <= 1'b0;
            end else if (even_sync && lev_r.step && center_r) begin
                single_r <= 1'b1;
            end else if (ch_tap || tape_now) begin
                single_r <= 1'b0;
            end
        end
    end

    // power fault latch: set wins over the manual clear
    always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            fault_r <= 1'b1;
        end else if (fault_set) begin
            fault_r <= 1'b1;
        end else if (mc_now) begin
            fault_r <= 1'b0;
        end
    end

    // start, tape and clear pulses
    always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            start_r  <= 1'b0;
            tape_r   <= 1'b0;
            mc_int_r <= 1'b0;
            mc_ext_r <= 1'b0;
        end else begin
            start_r  <= start_now;
            tape_r   <= tape_now;
            mc_int_r <= mc_now;
            mc_ext_r <= mc_now;
        end
    end

    // operational registers, storage strobes
    always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            acc_r      <= ACCUM_RST;
            pa_r       <= PADDR_RST;
            sd_r       <= SDATA_RST;
            swept_r    <= 1'b0;
            rd_pend_r  <= 1'b0;
            st_wr_r    <= 1'b0;
            st_rd_r    <= 1'b0;
            st_addr_r  <= PADDR_RST;
            st_wdata_r <= SDATA_RST;
        end else begin
            st_wr_r   <= enter_now;
            st_rd_r   <= sweep_now;
            rd_pend_r <= st_rd_r;
            if (sweep_now) begin
                swept_r <= 1'b1;
            end else if (center_r && lev_centre && !running) begin
                swept_r <= 1'b0;
            end
            if (mc_now) begin
                acc_r <= ACCUM_RST;
                pa_r  <= PADDR_RST;
                sd_r  <= SDATA_RST;
            end else if (enter_now) begin
                st_addr_r  <= pa_r;
                st_wdata_r <= acc_r;
                sd_r       <= acc_r;
                acc_r      <= ACCUM_RST;
                pa_r       <= pa_r + 12'h001;
            end else if (sweep_now) begin
                st_addr_r <= pa_r;
            end else if (rd_pend_r) begin
                sd_r <= I_STORE_RDATA;
                pa_r <= pa_r + 12'h001;
            end else if (I_REG_WR && sel_accum) begin
                acc_r <= I_REG_WDATA[WORD_W-1:0];
            end else if (I_REG_WR && sel_paddr) begin
                pa_r <= I_REG_WDATA[ADDR_W-1:0];
            end
        end
    end

    // register read data valid only in the cycle after the strobe
    always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            rdata_r <= 32'h00000000;
        end else begin
            rdata_r <= I_REG_RD ? rd_mux : 32'h00000000;
        end
    end

    crc_timing_chain u_chain (
        .i_clk   (I_REF_CLK),
        .i_rst_b (I_RST_B),
        .i_start (start_r),
        .i_recirc(cont_r),
        .i_halt  (fault_r),
        .o_pulse (ch_pulse),
        .o_stage (ch_stage),
        .o_exc   (ch_exc),
        .o_tap3  (ch_tap),
        .o_done  (ch_done),
        .o_busy  (ch_busy)
    );

    assign O_REG_RDATA        = rdata_r;
    assign O_STORE_ADDR       = st_addr_r;
    assign O_STORE_WDATA      = st_wdata_r;
    assign O_STORE_WR         = st_wr_r;
    assign O_STORE_RD         = st_rd_r;
    assign O_CHAIN_START      = start_r;
    assign O_TIMING_PULSE     = ch_pulse;
    assign O_CHAIN_STAGE      = ch_stage;
    assign O_EXCURSION        = ch_exc;
    assign O_CHAIN_THIRD_TAP  = ch_tap;
    assign O_RECIRC_HOLD      = cont_r;
    assign O_LOAD_TERM        = lev_r.load;
    assign O_NOT_LOAD_TERM    = !lev_r.load;
    assign O_TAPE_READ_START  = tape_r;
    assign O_MASTER_CLEAR_INT = mc_int_r;
    assign O_MASTER_CLEAR_EXT = mc_ext_r;
    assign O_POWER_FAULT      = fault_r;
    assign O_STORAGE_ENABLE   = !fault_r;

    // helper counters for the checks below
    logic [4:0] pcnt_r;
    logic [5:0] gap_r;
    always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            pcnt_r <= 5'h00;
            gap_r  <= 6'h00;
        end else begin
            pcnt_r <= (ch_done || start_r) ? 5'h00 : pcnt_r + 5'(ch_pulse);
            gap_r  <= ch_pulse ? 6'h00 : start_r ? 6'h3F : gap_r + 6'h01;
        end
    end

    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RST_B);

    sequence s_run_armed;
        even_sync && lev_r.run && center_r && !fault_r;
    endsequence
    sequence s_start_issued;
        start_r ##1 ch_busy;
    endsequence

    chk_run_latch_set: assert property (s_run_armed |=> cont_r)
        else $error("continuous latch not set on even sync");
    chk_start_odd: assert property ($rose(start_r) |-> $past(odd_sync) && !O_LOAD_TERM)
        else $error("start not on odd sync or in load mode");
    chk_start_busy: assert property (s_start_issued |-> ##[1:200] ch_tap)
        else $error("no third tap after chain start");
    chk_tap_clears: assert property (ch_tap && !lev_centre |=> !center_r && !single_r)
        else $error("third tap did not clear flags");
    chk_cycle_length: assert property (ch_done |-> ch_pulse && pcnt_r == 5'd23)
        else $error("storage cycle not 24 pulses");
    chk_pulse_gap: assert property (ch_pulse |-> gap_r == 6'(PULSE_SPACING_CYC - 1))
        else $error("chain pulse spacing wrong");
    chk_recirc_run: assert property (ch_done && cont_r && $past(cont_r, 400) && !fault_r |=> ch_busy)
        else $error("chain stopped while running");
    chk_clear_zero: assert property (mc_int_r |-> acc_r == 8'h00 && pa_r == 12'h000 && !$past(running))
        else $error("master clear bad");
    chk_clear_pair: assert property (mc_int_r == mc_ext_r)
        else $error("master clear outputs differ");
    chk_enter_write: assert property (enter_now |=> st_wr_r && acc_r == 8'h00
                                      && pa_r == $past(pa_r) + 12'h001 && st_wdata_r == $past(acc_r))
        else $error("enter write wrong");
    chk_fault_block: assert property (fault_r |=> !st_wr_r && !st_rd_r && !start_r)
        else $error("storage active under fault");
    chk_powerup_hold: assert property (delay_low |=> fault_r)
        else $error("fault latch not set by delay input");
endmodule // crc_console_run_control

/* File: verification/crc_lever_panel.sv */
// lever panel model with contact chatter after each move
`timescale 1ns/1ps
module crc_lever_panel import crc_pkg::*; (
    input  wire logic       i_clk,
    input  wire logic [1:0] i_rs,
    input  wire logic [1:0] i_lc,
    input  wire logic [1:0] i_es,
    output crc_lever_t      o_levers
);
    logic [5:0] want;
    logic [5:0] prev_r = 6'h00;
    logic [5:0] old_r  = 6'h00;
    logic [2:0] bnc_r  = 3'h0;
    assign want = {i_rs == 2'h1, i_rs == 2'h2, i_lc == 2'h1, i_lc == 2'h2, i_es == 2'h1, i_es == 2'h2};
    always_ff @(posedge i_clk) begin
        if (want != prev_r) begin
            bnc_r <= 3'h6;
            old_r <= prev_r;
        end else if (bnc_r != 3'h0) begin
            bnc_r <= bnc_r - 3'h1;
        end
        prev_r <= want;
    end
    // moved contacts chatter between old and new position, others stay put
    assign o_levers = crc_lever_t'(bnc_r[0] ? old_r : want);
endmodule // crc_lever_panel

/* File: verification/console_run_control_bench.sv */
// self-checking bench for console run control
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
    checked++; \
    if ((g) !== (e)) begin \
        fail_count++; \
        $display("mismatch %s expected %0h seen %0h", nm, e, g); \
    end \
end
module console_run_control_bench import crc_pkg::*; ();
    logic        clk;
    logic        rst_b;
    logic        pwr_ok;
    logic        dly_b;
    logic [1:0]  rs;
    logic [1:0]  lc;
    logic [1:0]  es;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr_s;
    logic        rd_s;
    logic [31:0] rdata;
    logic [7:0]  srdata;
    crc_lever_t  levers;
    logic        cstart, tpulse, recirc, load_t, nload_t, tape, mci, mce, fault, sto_en, swr, srd, tap3;
    logic [2:0]  stage;
    logic [1:0]  exc;
    logic [11:0] saddr;
    logic [7:0]  swdata;
    logic [11:0] wr_addr;
    logic [7:0]  wr_data;
    int          checked = 0, fail_count = 0, cyc = 0, gap = 0;
    int          n_start = 0, n_pulse = 0, n_mci = 0, n_mce = 0, n_wr = 0, n_rd = 0, n_tape = 0, n_tap3 = 0;

    crc_lever_panel panel (.i_clk(clk), .i_rs(rs), .i_lc(lc), .i_es(es), .o_levers(levers));
    crc_console_run_control #(.POWERUP_CYCLES(50)) dut (
        .I_REF_CLK(clk), .I_RST_B(rst_b), .I_LEVERS(levers), .I_POWER_OK(pwr_ok),
        .I_POWERUP_DELAY_B(dly_b), .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .I_REG_WR(wr_s),
        .I_REG_RD(rd_s), .O_REG_RDATA(rdata), .I_STORE_RDATA(srdata), .O_STORE_ADDR(saddr),
        .O_STORE_WDATA(swdata), .O_STORE_WR(swr), .O_STORE_RD(srd), .O_CHAIN_START(cstart),
        .O_TIMING_PULSE(tpulse), .O_CHAIN_STAGE(stage), .O_EXCURSION(exc), .O_CHAIN_THIRD_TAP(tap3),
        .O_RECIRC_HOLD(recirc), .O_LOAD_TERM(load_t), .O_NOT_LOAD_TERM(nload_t),
        .O_TAPE_READ_START(tape), .O_MASTER_CLEAR_INT(mci), .O_MASTER_CLEAR_EXT(mce),
        .O_POWER_FAULT(fault), .O_STORAGE_ENABLE(sto_en));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic close_out();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // storage responder and event counters
    always @(posedge clk) begin
        cyc++;
        gap++;
        srdata <= saddr[7:0] ^ 8'h5A;
        n_start += int'(cstart);
        n_mci += int'(mci);
        n_mce += int'(mce);
        n_rd += int'(srd);
        n_tape += int'(tape);
        n_tap3 += int'(tap3);
        if (swr === 1'b1) begin
            n_wr++;
            wr_addr = saddr;
            wr_data = swdata;
        end
        if (tpulse === 1'b1) begin
            if (stage === 3'h0) `CHK("pass", (n_pulse / 8) % 3, exc)
            n_pulse++;
            if (stage !== 3'h0) `CHK("spacing", 45, gap)
            gap = 0;
        end
        if (cyc == 40000) begin
            fail_count++;
            close_out();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask

    task automatic lever(input logic [1:0] r, input logic [1:0] l, input logic [1:0] e, input int n);
        @(posedge clk);
        rs <= r;
        lc <= l;
        es <= e;
        repeat (n) @(posedge clk);
    endtask

    initial begin
        logic [31:0] v;
        logic [11:0] p;
        logic [7:0]  a;
        int          p0;
        int          s0;
        int          t0;
        void'($urandom(90446));
        {rst_b, rs, lc, es, addr, wdata, wr_s, rd_s} = '0;
        pwr_ok = 1'b1;
        dly_b = 1'b1;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        `CHK("fault", 1'b1, fault)
        `CHK("nload", 1'b1, nload_t)
        rd(8'h10, v);
        `CHK("unmapped", 32'h0, v)
        repeat (60) @(posedge clk);
        `CHK("fault held", 1'b1, fault)
        v = $urandom;
        wr(REG_ACCUM, {24'h0, v[7:0]});
        wr(REG_PADDR, {20'h0, v[19:8]});
        lever(2'h0, 2'h2, 2'h0, 200);
        lever(2'h0, 2'h0, 2'h0, 200);
        `CHK("mc int", 1, n_mci)
        `CHK("mc ext", 1, n_mce)
        `CHK("sto en", 1'b1, sto_en)
        rd(REG_PADDR, v);
        `CHK("paddr", 32'h0, v)
        s0 = n_start;
        p0 = n_pulse;
        v = $urandom;
        p = v[19:8];
        a = v[7:0];
        wr(REG_ACCUM, {24'h0, a});
        wr(REG_PADDR, {20'h0, p});
        lever(2'h2, 2'h0, 2'h1, 200);
        lever(2'h0, 2'h0, 2'h1, 1400);
        `CHK("starts", s0 + 1, n_start)
        `CHK("pulses", p0 + 24, n_pulse)
        `CHK("writes", 1, n_wr)
        `CHK("wr addr", p, wr_addr)
        `CHK("wr data", a, wr_data)
        rd(REG_ACCUM, v);
        `CHK("accum", 32'h0, v)
        // sweep under run; clear lever refused while running
        s0 = n_start;
        p0 = n_pulse;
        lever(2'h1, 2'h0, 2'h2, 2000);
        `CHK("recirc", 1'b1, recirc)
        lever(2'h1, 2'h2, 2'h2, 200);
        lever(2'h1, 2'h0, 2'h2, 1500);
        lever(2'h0, 2'h0, 2'h2, 1700);
        `CHK("recirc off", 1'b0, recirc)
        `CHK("mc refused", 1, n_mci)
        `CHK("run cycles", 1'b1, n_pulse - p0 > 48)
        `CHK("whole cycles", 0, (n_pulse - p0) % 24)
        `CHK("sweeps", 1, n_rd)
        `CHK("taps", n_start, n_tap3)
        p = p + 12'h1;
        rd(REG_SDATA, v);
        `CHK("sdata", {24'h0, p[7:0] ^ 8'h5A}, v)
        rd(REG_PADDR, v);
        `CHK("sweep addr", {20'h0, p + 12'h1}, v)
        s0 = n_start;
        t0 = n_tape;
        lever(2'h0, 2'h1, 2'h0, 200);
        `CHK("load", 2'b10, {load_t, nload_t})
        lever(2'h2, 2'h1, 2'h0, 200);
        lever(2'h0, 2'h1, 2'h0, 1400);
        `CHK("tape", t0 + 1, n_tape)
        `CHK("no start", s0, n_start)
        lever(2'h1, 2'h0, 2'h0, 1000);
        pwr_ok <= 1'b0;
        lever(2'h0, 2'h0, 2'h0, 20);
        `CHK("fail", 2'b10, {fault, sto_en})
        p0 = n_pulse;
        lever(2'h0, 2'h0, 2'h0, 1400);
        `CHK("stopped", p0, n_pulse)
        pwr_ok <= 1'b1;
        lever(2'h0, 2'h2, 2'h0, 200);
        lever(2'h0, 2'h0, 2'h0, 200);
        `CHK("restored", 1'b0, fault)
        dly_b <= 1'b0;
        lever(2'h0, 2'h0, 2'h0, 20);
        dly_b <= 1'b1;
        lever(2'h0, 2'h0, 2'h0, 20);
        `CHK("delay pin", 1'b1, fault)
        close_out();
    end
endmodule // console_run_control_bench
